//--- rtl/sram_host.sv
// Host controller driving an asynchronous 32K x 8 static memory
// Assumes one request at a time; memory pins outside the clock domain
// Contract
// - Write strobe high through read
// - Address valid before select falls
// - Select held long before write end
// - Address held long before write end
// - Address settled at write start
// - Write strobe low at least pulse
// - Recovery after strobe rises
// - Recovery after select rises
// - Data driven before write ends
// - Data held through write end
// - Select high whenever address changes
// - Host never fights driving memory
`timescale 1ns/1ps
module sram_host #(
  parameter int ADDR_W = sram_host_pkg::ADDR_W,
  parameter int DATA_W = sram_host_pkg::DATA_W
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_select_n,
  output logic mem_gate_n,
  output logic mem_strobe_n,
  input wire logic [DATA_W-1:0] mem_data_in,
  output logic [DATA_W-1:0] mem_data_out,
  output logic mem_data_oe
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_ACCESS = 3'b011,
    ST_FLOAT = 3'b010,
    ST_RECOVER = 3'b110
  } state_e;

  localparam logic [3:0] READ_WAIT = 4'(sram_host_pkg::READ_WAIT_CYC + 2);
  localparam logic [3:0] WRITE_PULSE = 4'(sram_host_pkg::WRITE_PULSE_CYC);
  localparam logic [3:0] FLOAT_WAIT = 4'(sram_host_pkg::FLOAT_CYC);
  localparam logic [3:0] RECOVER_WAIT = 4'(sram_host_pkg::RECOVERY_CYC);

  state_e state;
  state_e next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic is_write;
  logic [DATA_W-1:0] data_sync;
  wire cnt_done = (cnt == 4'h0);
  wire start = (state == ST_IDLE) && req_valid;

  sram_pin_sync #(.WIDTH(DATA_W)) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .pin_in(mem_data_in),
    .pin_sync(data_sync)
  );

  always_comb begin
    next_state = state;
    next_cnt = cnt_done ? 4'h0 : cnt - 4'h1;
    case (state)
      ST_IDLE: begin
        if (req_valid) begin
          next_state = ST_SETUP;
          next_cnt = 4'h0;
        end
      end
      ST_SETUP: begin
        next_state = ST_ACCESS;
        next_cnt = is_write ? WRITE_PULSE - 4'h1 : READ_WAIT - 4'h1;
      end
      ST_ACCESS: begin
        if (cnt_done) begin
          next_state = ST_FLOAT;
          next_cnt = FLOAT_WAIT - 4'h1;
        end
      end
      ST_FLOAT: begin
        if (cnt_done) begin
          next_state = ST_RECOVER;
          next_cnt = RECOVER_WAIT - 4'h1;
        end
      end
      ST_RECOVER: begin
        if (cnt_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Address latched in idle, before any strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mem_addr <= '0;
      mem_data_out <= '0;
      is_write <= 1'b0;
    end else if (start) begin
      mem_addr <= req_addr;
      mem_data_out <= req_wdata;
      is_write <= req_write;
    end
  end

  wire is_write_next = start ? req_write : is_write;
  // Select falls one cycle after address set
  // Select rises after float in reads, with the strobe in writes, then recovery
  wire next_select_n = !(next_state == ST_ACCESS
                         || (next_state == ST_FLOAT && !is_write_next));
  // Strobe held high in read cycles
  // Strobe low for full pulse count
  wire next_strobe_n = !(next_state == ST_ACCESS && is_write_next);
  // Gate low only in read access
  // Gate rises, float wait before next use
  wire next_gate_n = !(next_state == ST_ACCESS && !is_write_next);
  // Data driven from setup, before strobe
  // Data held one cycle past strobe rise
  // Host drives only with gate high
  wire next_oe = is_write_next && (next_state == ST_SETUP
                 || next_state == ST_ACCESS || next_state == ST_FLOAT);
  // Sample at access end after sync delay
  wire capture = (state == ST_ACCESS) && cnt_done && !is_write;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mem_select_n <= 1'b1;
      mem_strobe_n <= 1'b1;
      mem_gate_n <= 1'b1;
      mem_data_oe <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      mem_select_n <= next_select_n;
      mem_strobe_n <= next_strobe_n;
      mem_gate_n <= next_gate_n;
      mem_data_oe <= next_oe;
      req_ready <= (next_state == ST_IDLE) && !start;
      rsp_valid <= capture || ((state == ST_RECOVER) && cnt_done && is_write);
      if (capture) begin
        rsp_rdata <= data_sync;
      end
    end
  end

  a_read_no_strobe: assert property (@(posedge core_clk) disable iff (srst)
    !mem_gate_n |-> mem_strobe_n) else $error("strobe low during read");
  a_no_contention: assert property (@(posedge core_clk) disable iff (srst)
    mem_data_oe |-> mem_gate_n) else $error("bus contention");
  a_addr_stable: assert property (@(posedge core_clk) disable iff (srst)
    !mem_select_n && !$past(mem_select_n) |-> $stable(mem_addr))
    else $error("address moved while selected");
  a_write_pulse: assert property (@(posedge core_clk) disable iff (srst)
    $fell(mem_strobe_n) |-> !mem_strobe_n [*2])
    else $error("write pulse too short");
  a_select_cover: assert property (@(posedge core_clk) disable iff (srst)
    !mem_strobe_n |-> !mem_select_n) else $error("strobe outside select");
  a_data_setup: assert property (@(posedge core_clk) disable iff (srst)
    $fell(mem_strobe_n) |-> $past(mem_data_oe)) else $error("data late");
  // Data held at strobe rise, unless reset cut the pulse
  a_data_hold: assert property (@(posedge core_clk) disable iff (srst)
    $rose(mem_strobe_n) && !$past(srst) |-> mem_data_oe) else $error("data hold lost");
  a_addr_setup: assert property (@(posedge core_clk) disable iff (srst)
    $fell(mem_select_n) |-> $stable(mem_addr)) else $error("addr at select");
  // Gate stays high a while after rising
  a_gate_float: assert property (@(posedge core_clk) disable iff (srst)
    $rose(mem_gate_n) |-> mem_gate_n [*2]) else $error("gate re-asserted");
  a_read_latency: assert property (@(posedge core_clk) disable iff (srst)
    $fell(mem_gate_n) |-> ##4 rsp_valid) else $error("read latency wrong");
  a_select_recovery: assert property (@(posedge core_clk) disable iff (srst)
    $rose(mem_select_n) |-> mem_select_n [*2]) else $error("select recovery short");
  a_write_addr_hold: assert property (@(posedge core_clk) disable iff (srst)
    !mem_strobe_n |-> $stable(mem_addr)) else $error("address moved in write");

  c_read: cover property (@(posedge core_clk) $fell(mem_gate_n));
  c_write: cover property (@(posedge core_clk) $fell(mem_strobe_n));
  c_back_to_back: cover property (@(posedge core_clk) rsp_valid ##[1:6] rsp_valid);
endmodule

//--- rtl/sram_host_pkg.sv
// Timing constants for the asynchronous static memory host controller
// Assumes a 25 MHz core clock; all counts derived from ns figures
package sram_host_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  // Fastest grade figures in ns
  localparam int READ_CYCLE_NS = 70;
  localparam int ADDR_TO_DATA_DELAY_NS = 70;
  localparam int GATE_TO_DATA_DELAY_NS = 35;
  localparam int UNGATE_FLOAT_DELAY_NS = 25;
  localparam int DESELECT_FLOAT_DELAY_NS = 25;
  localparam int WRITE_PULSE_MIN_NS = 55;
  localparam int SELECT_ACTIVE_MIN_NS = 65;
  localparam int ADDR_VALID_MIN_NS = 65;
  localparam int WRITE_DATA_SETUP_NS = 30;
  localparam int STROBE_RECOVERY_MIN_NS = 5;
  localparam int SELECT_RECOVERY_MIN_NS = 15;
  localparam int WRITE_CYCLE_NS = 70;
  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  // Read wait covers address access; sram_host adds the pin synchroniser slack
  localparam int READ_WAIT_CYC = ceil_cycles(ADDR_TO_DATA_DELAY_NS);
  localparam int WRITE_PULSE_CYC = ceil_cycles(WRITE_PULSE_MIN_NS);
  localparam int WRITE_SETUP_CYC = ceil_cycles(WRITE_DATA_SETUP_NS);
  localparam int FLOAT_CYC = ceil_cycles(UNGATE_FLOAT_DELAY_NS);
  localparam int RECOVERY_CYC = ceil_cycles(SELECT_RECOVERY_MIN_NS);
  localparam int CNT_W = 4;
endpackage

//--- rtl/sram_pin_sync.sv
// Two-stage synchroniser for the data bus inputs
// Assumes pins asynchronous to core_clk
`timescale 1ns/1ps
module sram_pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stage1 <= '0;
      pin_sync <= '0;
    end else begin
      stage1 <= pin_in;
      pin_sync <= stage1;
    end
  end
endmodule

//--- tb/sram_mem_model.sv
// Behavioural model of the byte-wide static memory on the host pins
// Assumes the bench resolves the shared data bus and feeds it back as bus
`timescale 1ns/1ps
module sram_mem_model #(
  parameter int ACCESS_NS = 70
) (
  input wire logic [14:0] addr,
  input wire logic select_n,
  input wire logic gate_n,
  input wire logic strobe_n,
  input wire logic [7:0] bus,
  output logic [7:0] q,
  output logic driving
);
  logic [7:0] mem [0:32767];
  wire wr_act = !select_n && !strobe_n;
  assign driving = !select_n && !gate_n && strobe_n;
  always @(driving or addr) begin
    if (driving)
      q <= #(ACCESS_NS) mem[addr];
    else
      q <= #25 ~q;
  end
  always @(negedge wr_act) begin
    mem[addr] = bus;
  end
  initial q = 8'h00;
endmodule

//--- tb/sram_host_tb.sv
// Self-checking bench for the static memory host controller
// Assumes sram_mem_model stands on the memory pins
`timescale 1ns/1ps
module sram_host_tb;
  logic core_clk, srst, req_valid, req_write, req_ready, rsp_valid;
  logic [14:0] req_addr, mem_addr, pa;
  logic [7:0] req_wdata, rsp_rdata, mem_data_out, q, bus;
  logic mem_select_n, mem_gate_n, mem_strobe_n, mem_data_oe, driving, ps;
  int miscompares = 0;
  int n_tests = 0;
  int slow = 0;
  // Setup cycle, access wait and two synchroniser stages
  localparam int RD_LAT = sram_host_pkg::READ_WAIT_CYC + 3;
  // Setup cycle, strobe pulse, float and recovery
  localparam int WR_LAT = 1 + sram_host_pkg::WRITE_PULSE_CYC + sram_host_pkg::FLOAT_CYC
    + sram_host_pkg::RECOVERY_CYC;
  assign bus = mem_data_oe ? mem_data_out : q;
  sram_host i_sram_host (.core_clk(core_clk), .srst(srst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .mem_addr(mem_addr), .mem_select_n(mem_select_n), .mem_gate_n(mem_gate_n),
    .mem_strobe_n(mem_strobe_n), .mem_data_in(bus), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe));
  sram_mem_model i_sram_mem_model (.addr(mem_addr), .select_n(mem_select_n),
    .gate_n(mem_gate_n), .strobe_n(mem_strobe_n), .bus(bus), .q(q), .driving(driving));
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [14:0] a, input logic [7:0] d, input int lat);
    int k;
    @(posedge core_clk);
    #1 req_valid = 1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    do @(negedge core_clk); while (req_ready !== 1'b1);
    @(posedge core_clk);
    #1 req_valid = 0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 20) begin
      @(posedge core_clk);
      #1 k++;
    end
    check(16'(k), 16'(lat), "answer latency"); // from accept edge to answer
    if (!wr) check(16'(rsp_rdata), 16'(d), "read data"); // stored byte
  endtask
  task automatic t_boundary();
    xfer(1'h1, 15'h0000, 8'hA5, WR_LAT);
    xfer(1'h1, 15'h7FFF, 8'h5A, WR_LAT);
    xfer(1'h0, 15'h0000, 8'hA5, RD_LAT);
    xfer(1'h0, 15'h7FFF, 8'h5A, RD_LAT);
  endtask
  task automatic t_walk();
    for (int i = 0; i < 15; i++) xfer(1'h1, 15'h0001 << i, 8'(i * 17 + 3), WR_LAT);
    xfer(1'h1, 15'h0004, 8'hC3, WR_LAT);
    for (int i = 14; i >= 0; i--)
      xfer(1'h0, 15'h0001 << i, (i == 2) ? 8'hC3 : 8'(i * 17 + 3), RD_LAT);
  endtask
  task automatic t_reset_mid();
    @(posedge core_clk);
    #1 req_valid = 1;
    req_write = 1;
    req_addr = 15'h1234;
    req_wdata = 8'hFF;
    repeat (3) @(posedge core_clk);
    #1 srst = 1;
    req_valid = 0;
    @(posedge core_clk);
    #1 srst = 0;
    check({mem_select_n, mem_gate_n, mem_strobe_n, mem_data_oe, req_ready, rsp_valid},
      16'h0038, "pins after reset"); // strobe idle
    xfer(1'h0, 15'h7FFF, 8'h5A, RD_LAT);
  endtask
  always @(negedge core_clk) begin
    if (!srst) begin
      check(mem_gate_n | mem_strobe_n, 1'h1, "strobe in read"); // strobe idle
      check((mem_addr === pa) | ps, 1'h1, "address moved"); // address stable
      check(mem_data_oe & driving, 1'h0, "bus fight"); // no contention
      check(mem_strobe_n | mem_data_oe, 1'h1, "data undriven"); // data held
      if (mem_strobe_n && slow > 0) check(slow >= 2, 1'h1, "short strobe"); // pulse width
    end
    slow = (mem_strobe_n || srst) ? 0 : slow + 1;
    pa = mem_addr;
    ps = srst | mem_select_n | mem_strobe_n;
  end
  // Far beyond some forty transfers of seven cycles each
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
  initial begin
    srst = 1;
    req_valid = 0;
    req_write = 0;
    req_addr = 15'h0000;
    req_wdata = 8'h00;
    ps = 1;
    pa = 15'h0000;
    repeat (5) @(posedge core_clk);
    #1 srst = 0;
    t_boundary();
    t_walk();
    t_reset_mid();
    wrap_up();
  end
endmodule
